/* hdl/hvp_pkg.sv */
// constants of the high-voltage parallel programming port
// assumes a 200 MHz system clock; pins already synchronous to it
package hvp_pkg;

	// ==================================================
	// command bytes and strobe actions
	localparam logic [7:0] CMD_NOP      = 8'h00;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE    = 8'h11;
	localparam logic [7:0] CMD_RD_SIG   = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE    = 8'h03;
	localparam logic [1:0] ACT_ADDR     = 2'h0;
	localparam logic [1:0] ACT_DATA     = 2'h1;
	localparam logic [1:0] ACT_CMD      = 2'h2;

	// ==================================================
	// memory geometry
	localparam int FLASH_AW = 14;
	localparam int PAGE_WW  = 6;
	localparam int PAGE_W   = 64;
	localparam int EE_AW    = 10;
	localparam int EE_PW    = 2;
	localparam int EE_PAGE  = 4;

	// ==================================================
	// fuse and lock layout, values after reset
	localparam logic [7:0] FUSE_LO_RST     = 8'hFF;
	localparam logic [7:0] FUSE_HI_RST     = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RST    = 8'hFF;
	localparam logic [7:0] LOCK_RST        = 8'hFF;
	localparam int         EE_PRESERVE_BIT = 3;
	localparam logic [7:0] BOOT_LOCK_MASK  = 8'h3C;
	// identity bytes: arbitrary values
	localparam logic [7:0] SIG_BYTE0       = 8'hA5;
	localparam logic [7:0] SIG_BYTE1       = 8'h5A;
	localparam logic [7:0] SIG_BYTE2       = 8'h01;
	localparam logic [7:0] CAL_BYTE        = 8'h80;

	// ==================================================
	// timing
	localparam int CLK_MHZ       = 200;
	localparam int ENTRY_HOLD_NS = 10000;
	localparam int FLASH_WR_US   = 4500;
	localparam int EE_WR_US      = 3600;
	localparam int FUSE_WR_US    = 4500;
	localparam int TMR_W         = 20;
	localparam logic [11:0] ENTRY_CYC =
		12'((ENTRY_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TMR_W-1:0] FLASH_WR_CYC =
		TMR_W'(FLASH_WR_US * CLK_MHZ);
	localparam logic [TMR_W-1:0] EE_WR_CYC =
		TMR_W'(EE_WR_US * CLK_MHZ);
	localparam logic [TMR_W-1:0] FUSE_WR_CYC =
		TMR_W'(FUSE_WR_US * CLK_MHZ);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_ERASE = 2'h1,
		ST_WAIT  = 2'h2
	} hvp_op_t;

endpackage : hvp_pkg

/* hdl/hvp_edge.sv */
// edge detector for the programming strobes
// assumes levels synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module hvp_edge #(
	parameter int W = 3
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] prev_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			prev_q <= '0;
		else if (clk_en)
			prev_q <= level;
	end

	assign rise = level & ~prev_q;
	assign fall = ~level & prev_q;
endmodule : hvp_edge
`default_nettype wire

/* hdl/hvp_timer.sv */
// down-counter timing one self-timed nonvolatile write
// assumes start is a one-cycle pulse; cycles at least 1
`timescale 1ns/1ps
`default_nettype none
module hvp_timer (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	input  wire logic                       start,
	input  wire logic [hvp_pkg::TMR_W-1:0]  cycles,
	output logic                            done
);
	import hvp_pkg::*;
	logic [TMR_W-1:0] cnt_q;
	logic             run_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= cycles;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= TMR_W'(1)) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end else begin
					cnt_q <= cnt_q - TMR_W'(1);
				end
			end
		end
	end
endmodule : hvp_timer
`default_nettype wire

/* hdl/hvp_port.sv */
// device side of the high-voltage parallel programming port
// assumes programmer pins synchronous to sys_clk, data bus split in/out/oe
`timescale 1ns/1ps
`default_nettype none
module hvp_port #(
	parameter logic [hvp_pkg::TMR_W-1:0] FLASH_CYC = hvp_pkg::FLASH_WR_CYC,
	parameter logic [hvp_pkg::TMR_W-1:0] EE_CYC    = hvp_pkg::EE_WR_CYC,
	parameter logic [hvp_pkg::TMR_W-1:0] FUSE_CYC  = hvp_pkg::FUSE_WR_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       hv_present,
	input  wire logic       reset_pin_zero,
	input  wire logic       crystal_in_strobe,
	input  wire logic       action_select_hi,
	input  wire logic       action_select_lo,
	input  wire logic       byte_select_first,
	input  wire logic       byte_select_second,
	input  wire logic       page_buffer_load,
	input  wire logic       wr_n,
	input  wire logic       oe_n,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            ready_not_busy,
	output logic            prog_mode
);
	import hvp_pkg::*;

	// ==================================================
	// state
	logic [2:0]          rise;
	logic [2:0]          fall;
	logic                x_rise;
	logic                pl_rise;
	logic                wr_go;
	logic [11:0]         ent_cnt_q;
	logic                ent_done_q;
	logic [7:0]          cmd_q;
	logic [7:0]          addr_lo_q;
	logic [7:0]          addr_hi_q;
	logic [7:0]          data_lo_q;
	logic [7:0]          data_hi_q;
	logic [7:0]          fuse_lo_q;
	logic [7:0]          fuse_hi_q;
	logic [7:0]          fuse_ext_q;
	logic [7:0]          lock_q;
	logic [EE_PAGE-1:0]  ee_mask_q;
	logic [15:0]         pg_buf [PAGE_W];
	logic [7:0]          ee_buf [EE_PAGE];
	logic [15:0]         flash_mem [2**FLASH_AW];
	logic [7:0]          ee_mem [2**EE_AW];
	hvp_op_t             op_q;
	hvp_op_t             op_d;
	logic [FLASH_AW-1:0] er_idx_q;
	logic                er_last;
	logic                tmr_start;
	logic [TMR_W-1:0]    tmr_cyc;
	logic                tmr_done;
	logic [15:0]         fw;
	logic [7:0]          rd_d;
	logic                nop_load;

	function automatic logic [FLASH_AW-1:0] fl_addr(
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		fl_addr = {hi[FLASH_AW-9:0], lo};
	endfunction : fl_addr

	function automatic logic [EE_AW-1:0] ee_addr(
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		ee_addr = {hi[EE_AW-9:0], lo};
	endfunction : ee_addr

	hvp_edge #(.W(3)) u_edge (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.level   ({page_buffer_load, wr_n, crystal_in_strobe}),
		.rise    (rise),
		.fall    (fall)
	);

	hvp_timer u_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.start   (tmr_start),
		.cycles  (tmr_cyc),
		.done    (tmr_done)
	);

	assign x_rise   = rise[0] & prog_mode;
	assign pl_rise  = rise[2] & prog_mode;
	assign wr_go    = clk_en & prog_mode & fall[1] & (op_q == ST_IDLE);
	assign er_last  = (er_idx_q == {FLASH_AW{1'b1}});
	assign nop_load = x_rise & (data_in == CMD_NOP)
		& ({action_select_hi, action_select_lo} == ACT_CMD);

	// ==================================================
	// mode entry and exit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_mode  <= 1'b0;
			ent_cnt_q  <= '0;
			ent_done_q <= 1'b0;
		end else if (clk_en) begin
			if (reset_pin_zero) begin
				prog_mode  <= 1'b0;
				ent_cnt_q  <= '0;
				ent_done_q <= 1'b0;
			end else if (hv_present && !ent_done_q) begin
				if (ent_cnt_q == ENTRY_CYC - 12'h001) begin
					ent_done_q <= 1'b1;
					prog_mode  <= ({page_buffer_load, action_select_hi,
						action_select_lo, byte_select_first} == 4'h0);
				end else begin
					ent_cnt_q <= ent_cnt_q + 12'h001;
				end
			end
		end
	end

	// ==================================================
	// command, address and data loading
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q     <= CMD_NOP;
			addr_lo_q <= 8'h00;
			addr_hi_q <= 8'h00;
			data_lo_q <= 8'h00;
			data_hi_q <= 8'h00;
		end else if (clk_en && x_rise) begin
			case ({action_select_hi, action_select_lo})
			ACT_CMD: cmd_q <= data_in;
			ACT_ADDR: begin
				if (byte_select_first)
					addr_hi_q <= data_in;
				else
					addr_lo_q <= data_in;
			end
			ACT_DATA: begin
				if (byte_select_first)
					data_hi_q <= data_in;
				else
					data_lo_q <= data_in;
			end
			default: ;
			endcase
		end
	end

	// ==================================================
	// page buffers
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			if (nop_load) begin
				for (int i = 0; i < PAGE_W; i++)
					pg_buf[i] <= 16'hFFFF;
			end else if (pl_rise && byte_select_first) begin
				if (cmd_q == CMD_WR_FLASH)
					pg_buf[addr_lo_q[PAGE_WW-1:0]] <= {data_hi_q, data_lo_q};
				if (cmd_q == CMD_WR_EE)
					ee_buf[addr_lo_q[EE_PW-1:0]] <= data_lo_q;
			end
		end
	end

	// only bytes latched since the last page write are stored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ee_mask_q <= '0;
		else if (clk_en) begin
			if (nop_load)
				ee_mask_q <= '0;
			else if (wr_go && cmd_q == CMD_WR_EE && !byte_select_first)
				ee_mask_q <= '0;
			else if (pl_rise && byte_select_first && cmd_q == CMD_WR_EE)
				ee_mask_q[addr_lo_q[EE_PW-1:0]] <= 1'b1;
		end
	end

	// ==================================================
	// nonvolatile arrays
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			if (op_q == ST_ERASE) begin
				flash_mem[er_idx_q] <= 16'hFFFF;
				if (fuse_hi_q[EE_PRESERVE_BIT] && er_idx_q[13:10] == 4'h0)
					ee_mem[er_idx_q[EE_AW-1:0]] <= 8'hFF;
			end else if (wr_go) begin
				case (cmd_q)
				CMD_WR_FLASH: begin
					// cells only go from 1 to 0, hence the erase first
					for (int i = 0; i < PAGE_W; i++)
						flash_mem[fl_addr(addr_hi_q, {addr_lo_q[7:6],
							6'(i)})] <= flash_mem[fl_addr(addr_hi_q,
							{addr_lo_q[7:6], 6'(i)})] & pg_buf[i];
				end
				CMD_WR_EE: begin
					if (!byte_select_first) begin
						for (int i = 0; i < EE_PAGE; i++)
							if (ee_mask_q[i])
								ee_mem[ee_addr(addr_hi_q, {addr_lo_q[7:2],
									2'(i)})] <= ee_buf[i];
					end
				end
				default: ;
				endcase
			end
		end
	end

	// ==================================================
	// fuses and locks
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_lo_q  <= FUSE_LO_RST;
			fuse_hi_q  <= FUSE_HI_RST;
			fuse_ext_q <= FUSE_EXT_RST;
			lock_q     <= LOCK_RST;
		end else if (clk_en) begin
			if (op_q == ST_ERASE && er_last) begin
				lock_q <= 8'hFF;
			end else if (wr_go) begin
				case (cmd_q)
				CMD_WR_FUSE: begin
					case ({byte_select_second, byte_select_first})
					2'h0: fuse_lo_q <= data_lo_q;
					2'h1: fuse_hi_q <= data_lo_q;
					2'h2: fuse_ext_q <= data_lo_q;
					default: ;
					endcase
				end
				CMD_WR_LOCK: begin
					if (lock_q[1:0] == 2'h0)
						lock_q <= lock_q & (data_lo_q | BOOT_LOCK_MASK);
					else
						lock_q <= lock_q & data_lo_q;
				end
				default: ;
				endcase
			end
		end
	end

	// ==================================================
	// operation sequencer
	always_comb begin
		op_d      = op_q;
		tmr_start = 1'b0;
		tmr_cyc   = FUSE_CYC;
		case (op_q)
		ST_IDLE: begin
			if (wr_go) begin
				case (cmd_q)
				CMD_ERASE: op_d = ST_ERASE;
				CMD_WR_FLASH: begin
					op_d      = ST_WAIT;
					tmr_start = 1'b1;
					tmr_cyc   = FLASH_CYC;
				end
				CMD_WR_EE: begin
					if (!byte_select_first) begin
						op_d      = ST_WAIT;
						tmr_start = 1'b1;
						tmr_cyc   = EE_CYC;
					end
				end
				CMD_WR_FUSE, CMD_WR_LOCK: begin
					op_d      = ST_WAIT;
					tmr_start = 1'b1;
				end
				default: ;
				endcase
			end
		end
		ST_ERASE: if (er_last) op_d = ST_IDLE;
		ST_WAIT: if (tmr_done) op_d = ST_IDLE;
		default: op_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_q           <= ST_IDLE;
			er_idx_q       <= '0;
			ready_not_busy <= 1'b1;
		end else if (clk_en) begin
			op_q           <= op_d;
			ready_not_busy <= (op_d == ST_IDLE);
			if (op_q == ST_ERASE)
				er_idx_q <= er_idx_q + 14'h0001;
			else
				er_idx_q <= '0;
		end
	end

	// ==================================================
	// read-back
	assign fw = flash_mem[fl_addr(addr_hi_q, addr_lo_q)];

	always_comb begin
		rd_d = 8'hFF;
		case (cmd_q)
		CMD_RD_FLASH: rd_d = byte_select_first ? fw[15:8] : fw[7:0];
		CMD_RD_EE: begin
			if (!byte_select_first)
				rd_d = ee_mem[ee_addr(addr_hi_q, addr_lo_q)];
		end
		CMD_RD_FUSE: begin
			case ({byte_select_second, byte_select_first})
			2'h0: rd_d = fuse_lo_q;
			2'h3: rd_d = fuse_hi_q;
			2'h2: rd_d = fuse_ext_q;
			default: rd_d = lock_q;
			endcase
		end
		CMD_RD_SIG: begin
			if (byte_select_first) begin
				if (addr_lo_q == 8'h00)
					rd_d = CAL_BYTE;
			end else begin
				case (addr_lo_q)
				8'h00: rd_d = SIG_BYTE0;
				8'h01: rd_d = SIG_BYTE1;
				8'h02: rd_d = SIG_BYTE2;
				default: ;
				endcase
			end
		end
		default: ;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_oe  <= 1'b0;
			data_out <= 8'h00;
		end else if (clk_en) begin
			data_oe  <= prog_mode & ~oe_n;
			data_out <= (prog_mode && !oe_n) ? rd_d : 8'h00;
		end
	end

	// ==================================================
	// checks
	property p_entry;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(prog_mode) |-> $past(ent_cnt_q) == ENTRY_CYC - 12'h001;
	endproperty
	a_entry: assert property (p_entry)
		else $error("mode entered before the hold time");

	property p_exit;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		reset_pin_zero |=> !prog_mode;
	endproperty
	a_exit: assert property (p_exit)
		else $error("mode kept with reset pin at zero");

	property p_cmd_load;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		(x_rise && {action_select_hi, action_select_lo} == ACT_CMD)
			|=> cmd_q == $past(data_in);
	endproperty
	a_cmd_load: assert property (p_cmd_load)
		else $error("command byte not captured");

	property p_addr_hi;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		(x_rise && {action_select_hi, action_select_lo} == ACT_ADDR
			&& byte_select_first)
			|=> addr_hi_q == $past(data_in) && $stable(addr_lo_q);
	endproperty
	a_addr_hi: assert property (p_addr_hi)
		else $error("high address byte load wrong");

	property p_erase_busy;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		(wr_go && cmd_q == CMD_ERASE) |=> !ready_not_busy [*3];
	endproperty
	a_erase_busy: assert property (p_erase_busy)
		else $error("ready not low during erase");

	property p_erase_lock;
		@(posedge sys_clk) disable iff (!rst_n)
		(op_q == ST_IDLE && $past(op_q) == ST_ERASE) |-> lock_q == 8'hFF;
	endproperty
	a_erase_lock: assert property (p_erase_lock)
		else $error("locks not cleared after erase");

	property p_flash_read;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		(prog_mode && !oe_n && cmd_q == CMD_RD_FLASH && !byte_select_first)
			|=> data_oe && data_out == $past(fw[7:0]);
	endproperty
	a_flash_read: assert property (p_flash_read)
		else $error("flash low byte not driven");

	property p_bus_release;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		oe_n |=> !data_oe;
	endproperty
	a_bus_release: assert property (p_bus_release)
		else $error("bus driven with output enable high");

	property p_boot_lock;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		(wr_go && cmd_q == CMD_WR_LOCK && lock_q[1:0] == 2'h0)
			|=> lock_q[5:2] == $past(lock_q[5:2]);
	endproperty
	a_boot_lock: assert property (p_boot_lock)
		else $error("boot lock changed in restrictive mode");

	property p_fuse_read;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		(prog_mode && !oe_n && cmd_q == CMD_RD_FUSE && !byte_select_first
			&& !byte_select_second) |=> data_out == $past(fuse_lo_q);
	endproperty
	a_fuse_read: assert property (p_fuse_read)
		else $error("low fuse read-back wrong");

	property p_ready_idle;
		@(posedge sys_clk) disable iff (!rst_n)
		ready_not_busy |-> op_q == ST_IDLE;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("ready high during an operation");

endmodule : hvp_port
`default_nettype wire

/* tb/hvp_prog_model.sv */
// programmer model for the parallel programming port
// assumes pins sampled on sys_clk rising edges; bus resolved here
`timescale 1ns/1ps
`default_nettype none
module hvp_prog_model
	import hvp_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	input  wire logic       ready_not_busy,
	output logic            hv_present,
	output logic            reset_pin_zero,
	output logic            crystal_in_strobe,
	output logic            action_select_hi,
	output logic            action_select_lo,
	output logic            byte_select_first,
	output logic            byte_select_second,
	output logic            page_buffer_load,
	output logic            wr_n,
	output logic            oe_n,
	output logic      [7:0] data_in
);
	logic [7:0] drv = 8'h00;
	// wire level: device while it drives, else programmer value
	assign data_in = data_oe ? data_out : drv;
	// pins idle at 0000 pattern so entry latches it
	initial begin
		{hv_present, reset_pin_zero, crystal_in_strobe} = 3'h0;
		{action_select_hi, action_select_lo, byte_select_first} = 3'h0;
		{byte_select_second, page_buffer_load, wr_n, oe_n} = 4'h3;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic load(input logic [1:0] a, input logic bs, input logic [7:0] d);
		@(posedge sys_clk);
		{action_select_hi, action_select_lo} <= a;
		byte_select_first <= bs;
		drv <= d;
		@(posedge sys_clk);
		crystal_in_strobe <= 1'b1;
		@(posedge sys_clk);
		crystal_in_strobe <= 1'b0;
		@(posedge sys_clk);
		{action_select_hi, action_select_lo} <= 2'h3;
	endtask : load
	task automatic latch();
		@(posedge sys_clk);
		byte_select_first <= 1'b1;
		@(posedge sys_clk);
		page_buffer_load <= 1'b1;
		@(posedge sys_clk);
		page_buffer_load <= 1'b0;
		@(posedge sys_clk);
	endtask : latch
	task automatic write(input logic b2, input logic b1, output logic busy);
		@(posedge sys_clk);
		{byte_select_second, byte_select_first} <= {b2, b1};
		@(posedge sys_clk);
		wr_n <= 1'b0;
		@(posedge sys_clk);
		wr_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		busy = (ready_not_busy === 1'b0);
		// a device stuck busy is left to the bench watchdog
		while (ready_not_busy !== 1'b1)
			@(posedge sys_clk);
	endtask : write
	task automatic read(input logic b2, input logic b1, output logic [7:0] d);
		@(posedge sys_clk);
		{byte_select_second, byte_select_first} <= {b2, b1};
		oe_n <= 1'b0;
		drv <= ~drv;
		repeat (3) @(posedge sys_clk);
		d = data_in;
		oe_n <= 1'b1;
	endtask : read
endmodule : hvp_prog_model
`default_nettype wire

/* tb/hvp_tb.sv */
// self-checking bench for the parallel programming port
// assumes hvp_pkg, hvp_port and the programmer model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import hvp_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst_n   = 1'b0;
	logic       hv, rpz, stb, xh, xl, bs1, bs2, pgl, wr_n, oe_n;
	logic [7:0] din, dout;
	logic       doe, rdy, prog_mode, b;
	logic       clk_en  = 1'b1;
	logic [7:0] d;
	int         err_total = 0;
	int         compares  = 0;
	always #2.5 sys_clk = ~sys_clk;
	hvp_prog_model m_u (.sys_clk(sys_clk), .data_out(dout), .data_oe(doe),
		.ready_not_busy(rdy), .hv_present(hv), .reset_pin_zero(rpz),
		.crystal_in_strobe(stb), .action_select_hi(xh),
		.action_select_lo(xl), .byte_select_first(bs1),
		.byte_select_second(bs2), .page_buffer_load(pgl), .wr_n(wr_n),
		.oe_n(oe_n), .data_in(din));
	hvp_port #(.FLASH_CYC(20'd20), .EE_CYC(20'd20), .FUSE_CYC(20'd20)) dut_u (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .hv_present(hv),
		.reset_pin_zero(rpz), .crystal_in_strobe(stb),
		.action_select_hi(xh), .action_select_lo(xl),
		.byte_select_first(bs1), .byte_select_second(bs2),
		.page_buffer_load(pgl), .wr_n(wr_n), .oe_n(oe_n), .data_in(din),
		.data_out(dout), .data_oe(doe), .ready_not_busy(rdy),
		.prog_mode(prog_mode));
	// ==========================================
	// shared helpers
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] c);
		m_u.load(ACT_CMD, 1'b0, c);
	endtask : cmd
	task automatic give_verdict();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict
	// ==========================================
	// scenarios
	task automatic t_entry();
		chk("mode_pre", prog_mode, 16'h0);
		@(posedge sys_clk) m_u.hv_present <= 1'b1;
		m_u.tick(1990);
		chk("mode_early", prog_mode, 16'h0);
		m_u.tick(20);
		chk("mode_on", prog_mode, 16'h1);
		m_u.tick(60000);
		$display("entry done");
	endtask : t_entry
	task automatic t_fuse();
		cmd(CMD_WR_FUSE);
		m_u.load(ACT_DATA, 1'b0, 8'h62);
		m_u.write(1'b0, 1'b0, b);
		chk("fuse_busy", b, 16'h1);
		m_u.load(ACT_DATA, 1'b0, 8'hD9);
		m_u.write(1'b0, 1'b1, b);
		m_u.load(ACT_DATA, 1'b0, 8'hFD);
		m_u.write(1'b1, 1'b0, b);
		cmd(CMD_RD_FUSE);
		m_u.read(1'b0, 1'b0, d);
		chk("fuse_lo", d, 16'h62);
		m_u.read(1'b1, 1'b1, d);
		chk("fuse_hi", d, 16'hD9);
		m_u.read(1'b1, 1'b0, d);
		chk("fuse_ext", d, 16'hFD);
		m_u.read(1'b0, 1'b1, d);
		chk("lock_rst", d, 16'hFF);
		$display("fuse done");
	endtask : t_fuse
	task automatic t_lock();
		cmd(CMD_WR_LOCK);
		m_u.load(ACT_DATA, 1'b0, 8'hFC);
		m_u.write(1'b0, 1'b0, b);
		m_u.load(ACT_DATA, 1'b0, 8'hC3);
		m_u.write(1'b0, 1'b0, b);
		cmd(CMD_RD_FUSE);
		m_u.read(1'b0, 1'b1, d);
		chk("lock_boot", d, 16'hFC);
		$display("lock done");
	endtask : t_lock
	task automatic t_erase();
		cmd(CMD_ERASE);
		m_u.write(1'b0, 1'b0, b);
		chk("erase_busy", b, 16'h1);
		cmd(CMD_RD_FUSE);
		m_u.read(1'b0, 1'b1, d);
		chk("erase_lock", d, 16'hFF);
		m_u.read(1'b1, 1'b1, d);
		chk("erase_fuse", d, 16'hD9);
		cmd(CMD_RD_EE);
		m_u.read(1'b0, 1'b0, d);
		chk("erase_ee", d, 16'hFF);
		$display("erase done");
	endtask : t_erase
	task automatic t_flash();
		cmd(CMD_NOP);
		cmd(CMD_WR_FLASH);
		m_u.load(ACT_ADDR, 1'b0, 8'h41);
		m_u.load(ACT_DATA, 1'b0, 8'h12);
		m_u.load(ACT_DATA, 1'b1, 8'h34);
		m_u.latch();
		m_u.load(ACT_ADDR, 1'b1, 8'h02);
		m_u.write(1'b0, 1'b0, b);
		chk("flash_busy", b, 16'h1);
		cmd(CMD_NOP);
		cmd(CMD_RD_FLASH);
		m_u.read(1'b0, 1'b0, d);
		chk("flash_lo", d, 16'h12);
		m_u.read(1'b0, 1'b1, d);
		chk("flash_hi", d, 16'h34);
		m_u.load(ACT_ADDR, 1'b0, 8'h01);
		m_u.read(1'b0, 1'b0, d);
		chk("flash_page", d, 16'hFF);
		$display("flash done");
	endtask : t_flash
	task automatic t_ee();
		cmd(CMD_WR_EE);
		m_u.load(ACT_ADDR, 1'b1, 8'h01);
		m_u.load(ACT_ADDR, 1'b0, 8'h06);
		m_u.load(ACT_DATA, 1'b0, 8'h9C);
		m_u.latch();
		m_u.write(1'b0, 1'b0, b);
		chk("ee_busy", b, 16'h1);
		cmd(CMD_RD_EE);
		m_u.read(1'b0, 1'b0, d);
		chk("ee_rd", d, 16'h9C);
		$display("eeprom done");
	endtask : t_ee
	task automatic t_sig();
		logic [7:0] sig [3];
		sig = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
		cmd(CMD_RD_SIG);
		for (int i = 0; i < 3; i++) begin
			m_u.load(ACT_ADDR, 1'b0, 8'(i));
			m_u.read(1'b0, 1'b0, d);
			chk("sig", d, {8'h00, sig[i]});
		end
		m_u.load(ACT_ADDR, 1'b0, 8'h00);
		m_u.read(1'b0, 1'b1, d);
		chk("cal", d, {8'h00, CAL_BYTE});
		m_u.tick(2);
		chk("bus_rel", doe, 16'h0);
		$display("signature done");
	endtask : t_sig
	task automatic t_undef();
		cmd(8'h55);
		m_u.load(ACT_DATA, 1'b0, 8'h00);
		m_u.write(1'b0, 1'b0, b);
		chk("undef_busy", b, 16'h0);
		cmd(CMD_RD_FUSE);
		m_u.read(1'b0, 1'b0, d);
		chk("undef_fuse", d, 16'h62);
		$display("undefined done");
	endtask : t_undef
	task automatic t_freeze();
		// a strobe seen while the clock enable is low must be lost
		@(posedge sys_clk) clk_en <= 1'b0;
		cmd(CMD_RD_SIG);
		@(posedge sys_clk) clk_en <= 1'b1;
		m_u.read(1'b0, 1'b0, d);
		chk("freeze_cmd", d, 16'h62);
		cmd(CMD_RD_SIG);
		m_u.read(1'b0, 1'b0, d);
		chk("thaw_cmd", d, {8'h00, SIG_BYTE0});
		$display("freeze done");
	endtask : t_freeze
	task automatic t_exit();
		@(posedge sys_clk);
		m_u.reset_pin_zero <= 1'b1;
		m_u.hv_present <= 1'b0;
		m_u.tick(3);
		chk("mode_off", prog_mode, 16'h0);
		$display("exit done");
	endtask : t_exit
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_entry();
		t_fuse();
		t_lock();
		t_erase();
		t_flash();
		t_ee();
		t_sig();
		t_undef();
		t_freeze();
		t_exit();
		give_verdict();
	end
	initial begin
		#450000;
		err_total++;
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
